/* verilog/detp_pkg.sv */
// Package with the constants shared by the debug emulator and trace port.
package detp_pkg;
   // ------------------------------------------------------------
   // Register map and fields
   // ------------------------------------------------------------
   localparam logic [11:0] DETP_OFS_CTRL = 12'h000;
   localparam logic [11:0] DETP_OFS_STATUS = 12'h004;
   localparam logic [11:0] DETP_OFS_DBGCTL = 12'h008;
   localparam int DETP_CTRL_TRACE_EN = 0;
   localparam int DETP_CTRL_PC_FULL_RATE = 1;
   localparam int DETP_ST_TRACE_ACTIVE = 0;
   localparam int DETP_ST_BREAK = 1;
   localparam int DETP_ST_HALT_SEEN = 2;
   localparam int DETP_ST_BOOT_LSB = 4;
   localparam int DETP_ST_CODE_LSB = 9;
   localparam int DETP_DBGCTL_BREAK_BIT = 12;
   localparam logic [31:0] DETP_DBGCTL_RESET = 32'h0000_0000;
   // Identity word is arbitrary and names no maker.
   localparam logic [31:0] DETP_IDCODE_VALUE = 32'h1234_5001;
   // ------------------------------------------------------------
   // Test access instructions and trace codes
   // ------------------------------------------------------------
   localparam logic [3:0] DETP_IR_IDCODE = 4'h1;
   localparam logic [3:0] DETP_IR_DBGCTL = 4'h8;
   localparam logic [3:0] DETP_IR_BYPASS = 4'hf;
   localparam logic [2:0] DETP_CODE_STALL = 3'h7;
   localparam logic [2:0] DETP_CODE_JUMP_PC = 3'h6;
   localparam logic [2:0] DETP_CODE_BRANCH_NOPC = 3'h5;
   localparam logic [2:0] DETP_CODE_EXCEPTION = 3'h4;
   localparam logic [2:0] DETP_CODE_SEQUENTIAL = 3'h3;
   localparam logic [2:0] DETP_CODE_TRACE_STALL = 3'h2;
   localparam logic [2:0] DETP_CODE_TRACE_TRIGGER = 3'h1;
   localparam logic [2:0] DETP_CODE_DEBUG_RUN = 3'h0;
   // ------------------------------------------------------------
   // Timing and test access controller states
   // ------------------------------------------------------------
   localparam logic [1:0] DETP_TRACE_DIV = 2'h3;
   localparam int DETP_SYNC_WIDTH = 3;
   typedef enum logic [3:0] {
      DETP_TLR, DETP_RTI, DETP_SEL_DR, DETP_CAP_DR, DETP_SH_DR, DETP_EX1_DR, DETP_PAU_DR, DETP_EX2_DR,
      DETP_UPD_DR, DETP_SEL_IR, DETP_CAP_IR, DETP_SH_IR, DETP_EX1_IR, DETP_PAU_IR, DETP_EX2_IR, DETP_UPD_IR
   } detp_tap_e;
endpackage

/* verilog/detp_sync.sv */
// Two-flop synchroniser for a group of test port pins.
`timescale 1ns/1ps
module detp_sync
   import detp_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [DETP_SYNC_WIDTH-1:0] async_in,
   output logic [DETP_SYNC_WIDTH-1:0] sync_out
);
   // ------------------------------------------------------------
   // One chain per bit
   // ------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < DETP_SYNC_WIDTH; i++)
      begin : g_bit
         logic meta_q;
         // The first stage feeds only the second, so metastability stays contained.
         always_ff @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               meta_q <= 1'b0;
               sync_out[i] <= 1'b0;
            end
            else
            begin
               meta_q <= async_in[i];
               sync_out[i] <= meta_q;
            end
         end
      end
   endgenerate
endmodule

/* verilog/detp_trace_div.sv */
// Divide-by-three slot generator and capture clock for the trace output.
`timescale 1ns/1ps
module detp_trace_div
   import detp_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic run,
   output logic slot,
   output logic cap_clk
);
   logic [1:0] cnt_q;
   wire last_w = (cnt_q == DETP_TRACE_DIV - 2'h1);

   // ------------------------------------------------------------
   // Counter
   // ------------------------------------------------------------
   // Slot pulses once per three cycles; the capture clock rises one cycle after the slot.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_q <= 2'h0;
         slot <= 1'b0;
         cap_clk <= 1'b0;
      end
      else
      begin
         cnt_q <= (!run || last_w) ? 2'h0 : cnt_q + 2'h1;
         slot <= run && last_w;
         cap_clk <= run && (cnt_q == 2'h0);
      end
   end
endmodule

/* verilog/detp_top.sv */
// Debug emulator test port with real-time trace, boot mode capture and APB registers.
//
// Our own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module detp_top
   import detp_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   input wire logic trst_n,
   output logic tdo_o,
   output logic tdo_oe,
   output logic trace_capture_clock,
   input wire logic [4:0] trace_status_bus_i,
   output logic [4:0] trace_status_bus_o,
   output logic [4:0] trace_status_bus_oe,
   input wire logic cold_reset_n,
   input wire logic debug_boot_in,
   input wire logic [2:0] core_code,
   input wire logic core_debug_mode,
   input wire logic [31:0] core_pc,
   output logic [4:0] boot_mode_bit,
   output logic debug_exception_req,
   output logic reset_exception_req,
   output logic debug_break_flag,
   output logic emulator_halt
);
   // ------------------------------------------------------------
   // Pin synchronisation and edge detection
   // ------------------------------------------------------------
   logic [DETP_SYNC_WIDTH-1:0] pins_s;
   logic tck_prev_q;
   logic cold_prev_q;
   // Test clock, mode select and data are foreign to pclk and pass two flops first.
   detp_sync u_sync (
      .clk(pclk),
      .rst_n(presetn),
      .async_in({tdi, tms, tck}),
      .sync_out(pins_s)
   );
   wire tck_s = pins_s[0];
   wire tms_s = pins_s[1];
   wire tdi_s = pins_s[2];
   wire tck_rise = tck_s && !tck_prev_q;
   wire tck_fall = !tck_s && tck_prev_q;
   wire cold_rise = cold_reset_n && !cold_prev_q;
   // The test reset clears the debug unit, including emulator_halt and, a cycle later, debug_break_flag, but no other core-facing output.
   wire dbg_rst_n = presetn && trst_n;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tck_prev_q <= 1'b0;
         cold_prev_q <= 1'b0;
      end
      else
      begin
         tck_prev_q <= tck_s;
         cold_prev_q <= cold_reset_n;
      end
   end

   // ------------------------------------------------------------
   // Test access controller
   // ------------------------------------------------------------
   detp_tap_e tap_q;
   detp_tap_e tap_d;
   logic [3:0] ir_q;
   logic [3:0] ir_sr_q;
   logic [31:0] dr_sr_q;
   logic bypass_q;
   logic [31:0] dbgctl_q;

   function automatic detp_tap_e tap_next(input detp_tap_e s, input logic m);
      case (s)
         DETP_TLR: tap_next = m ? DETP_TLR : DETP_RTI;
         DETP_RTI: tap_next = m ? DETP_SEL_DR : DETP_RTI;
         DETP_SEL_DR: tap_next = m ? DETP_SEL_IR : DETP_CAP_DR;
         DETP_CAP_DR: tap_next = m ? DETP_EX1_DR : DETP_SH_DR;
         DETP_SH_DR: tap_next = m ? DETP_EX1_DR : DETP_SH_DR;
         DETP_EX1_DR: tap_next = m ? DETP_UPD_DR : DETP_PAU_DR;
         DETP_PAU_DR: tap_next = m ? DETP_EX2_DR : DETP_PAU_DR;
         DETP_EX2_DR: tap_next = m ? DETP_UPD_DR : DETP_SH_DR;
         DETP_UPD_DR: tap_next = m ? DETP_SEL_DR : DETP_RTI;
         DETP_SEL_IR: tap_next = m ? DETP_TLR : DETP_CAP_IR;
         DETP_CAP_IR: tap_next = m ? DETP_EX1_IR : DETP_SH_IR;
         DETP_SH_IR: tap_next = m ? DETP_EX1_IR : DETP_SH_IR;
         DETP_EX1_IR: tap_next = m ? DETP_UPD_IR : DETP_PAU_IR;
         DETP_PAU_IR: tap_next = m ? DETP_EX2_IR : DETP_PAU_IR;
         DETP_EX2_IR: tap_next = m ? DETP_UPD_IR : DETP_SH_IR;
         DETP_UPD_IR: tap_next = m ? DETP_SEL_DR : DETP_RTI;
         default: tap_next = DETP_TLR;
      endcase
   endfunction

   // Mode select is only looked at on a test clock rise.
   always_comb
   begin
      tap_d = tap_q;
      if (tck_rise)
      begin
         tap_d = tap_next(tap_q, tms_s);
      end
   end

   wire sel_dbgctl = (ir_q == DETP_IR_DBGCTL);
   wire sel_idcode = (ir_q == DETP_IR_IDCODE);
   wire sh_dr = (tap_q == DETP_SH_DR);
   wire sh_ir = (tap_q == DETP_SH_IR);
   wire dr_lsb = (sel_dbgctl || sel_idcode) ? dr_sr_q[0] : bypass_q;
   wire [31:0] dr_capture = sel_dbgctl ? dbgctl_q : DETP_IDCODE_VALUE;
   wire dbgctl_upd = tck_rise && (tap_q == DETP_UPD_DR) && sel_dbgctl;

   always_ff @(posedge pclk or negedge dbg_rst_n)
   begin
      if (!dbg_rst_n)
      begin
         tap_q <= DETP_TLR;
      end
      else
      begin
         tap_q <= tap_d;
      end
   end

   // Shift paths: the selected register moves one bit per test clock rise.
   always_ff @(posedge pclk or negedge dbg_rst_n)
   begin
      if (!dbg_rst_n)
      begin
         ir_q <= DETP_IR_IDCODE;
         ir_sr_q <= 4'h0;
         dr_sr_q <= 32'h0000_0000;
         bypass_q <= 1'b0;
      end
      else if (tck_rise)
      begin
         if (tap_q == DETP_TLR)
            ir_q <= DETP_IR_IDCODE;
         else if (tap_q == DETP_UPD_IR)
            ir_q <= ir_sr_q;
         if (tap_q == DETP_CAP_IR)
            ir_sr_q <= 4'h1;
         else if (sh_ir)
            ir_sr_q <= {tdi_s, ir_sr_q[3:1]};
         if (tap_q == DETP_CAP_DR)
         begin
            dr_sr_q <= dr_capture;
            bypass_q <= 1'b0;
         end
         else if (sh_dr)
         begin
            dr_sr_q <= {tdi_s, dr_sr_q[31:1]};
            bypass_q <= tdi_s;
         end
      end
   end

   // Debug control: the boot level sets the break bit and wins over an update.
   wire [31:0] dbgctl_upd_val = dbgctl_upd ? dr_sr_q : dbgctl_q;
   wire [31:0] dbgctl_set = {19'h0, debug_boot_in, 12'h000};
   always_ff @(posedge pclk or negedge dbg_rst_n)
   begin
      if (!dbg_rst_n)
      begin
         dbgctl_q <= DETP_DBGCTL_RESET;
      end
      else
      begin
         dbgctl_q <= dbgctl_upd_val | dbgctl_set;
      end
   end

   // ------------------------------------------------------------
   // Trace mode control and emulator interrupt
   // ------------------------------------------------------------
   logic trace_en_q;
   logic pc_full_rate_q;
   logic halt_seen_q;
   logic slot;
   logic cap_clk;
   logic apb_wr;
   logic [31:0] apb_wdata;
   logic [11:0] apb_addr;
   wire ctrl_wr = apb_wr && (apb_addr == DETP_OFS_CTRL);
   wire status_wr = apb_wr && (apb_addr == DETP_OFS_STATUS);
   // An active-low serial input in trace mode stops trace and returns to run time.
   wire emulator_interrupt_n_hit = trace_en_q && !tdi_s;

   // A software enable in the same cycle as the interrupt wins.
   always_ff @(posedge pclk or negedge dbg_rst_n)
   begin
      if (!dbg_rst_n)
      begin
         trace_en_q <= 1'b0;
         pc_full_rate_q <= 1'b0;
         halt_seen_q <= 1'b0;
         emulator_halt <= 1'b0;
      end
      else
      begin
         if (ctrl_wr)
         begin
            trace_en_q <= apb_wdata[DETP_CTRL_TRACE_EN];
            pc_full_rate_q <= apb_wdata[DETP_CTRL_PC_FULL_RATE];
         end
         else if (emulator_interrupt_n_hit)
            trace_en_q <= 1'b0;
         halt_seen_q <= emulator_interrupt_n_hit || (halt_seen_q && !(status_wr && apb_wdata[DETP_ST_HALT_SEEN]));
         emulator_halt <= emulator_interrupt_n_hit;
      end
   end

   detp_trace_div u_div (
      .clk(pclk),
      .rst_n(dbg_rst_n),
      .run(trace_en_q),
      .slot(slot),
      .cap_clk(cap_clk)
   );

   // ------------------------------------------------------------
   // Trace program counter and status code
   // ------------------------------------------------------------
   logic [31:0] pc_sr_q;
   logic [5:0] pc_left_q;
   logic [2:0] code_q;
   wire [2:0] code_now = core_debug_mode ? DETP_CODE_DEBUG_RUN : core_code;
   wire pc_load = slot && ((code_now == DETP_CODE_JUMP_PC) || (code_now == DETP_CODE_EXCEPTION));
   wire pc_step = (pc_left_q != 6'h00) && (pc_full_rate_q || slot);

   // Only jump targets and exceptions are sent; sequential flow is implied.
   always_ff @(posedge pclk or negedge dbg_rst_n)
   begin
      if (!dbg_rst_n)
      begin
         pc_sr_q <= 32'h0000_0000;
         pc_left_q <= 6'h00;
         code_q <= DETP_CODE_SEQUENTIAL;
      end
      else
      begin
         if (pc_load)
         begin
            pc_sr_q <= core_pc;
            pc_left_q <= 6'h20;
         end
         else if (pc_step)
         begin
            pc_sr_q <= {1'b0, pc_sr_q[31:1]};
            pc_left_q <= pc_left_q - 6'h01;
         end
         if (slot)
            code_q <= code_now;
      end
   end

   // ------------------------------------------------------------
   // Serial output pin
   // ------------------------------------------------------------
   // Test data moves on the falling test clock; trace drives the pin every cycle.
   always_ff @(posedge pclk or negedge dbg_rst_n)
   begin
      if (!dbg_rst_n)
      begin
         tdo_o <= 1'b0;
         tdo_oe <= 1'b0;
      end
      else if (trace_en_q)
      begin
         tdo_o <= pc_sr_q[0];
         tdo_oe <= 1'b1;
      end
      else if (tck_fall)
      begin
         tdo_o <= sh_ir ? ir_sr_q[0] : dr_lsb;
         tdo_oe <= sh_ir || sh_dr;
      end
   end

   // ------------------------------------------------------------
   // Boot mode, status pins and reset exception choice
   // ------------------------------------------------------------
   // Pins stay undriven in cold reset so the board can present boot straps.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         boot_mode_bit <= 5'h00;
         trace_status_bus_o <= 5'h00;
         trace_status_bus_oe <= 5'h00;
         trace_capture_clock <= 1'b0;
         debug_exception_req <= 1'b0;
         reset_exception_req <= 1'b0;
         debug_break_flag <= 1'b0;
      end
      else
      begin
         if (cold_rise)
            boot_mode_bit <= trace_status_bus_i;
         trace_status_bus_o <= {2'b00, code_q};
         trace_status_bus_oe <= {2'b00, {3{cold_reset_n}}};
         trace_capture_clock <= cap_clk;
         // The level at the end of reset decides; nothing about it is held.
         debug_exception_req <= cold_rise && debug_boot_in;
         reset_exception_req <= cold_rise && !debug_boot_in;
         debug_break_flag <= dbgctl_q[DETP_DBGCTL_BREAK_BIT];
      end
   end

   // ------------------------------------------------------------
   // APB slave
   // ------------------------------------------------------------
   wire setup = psel && !penable;
   wire known = (paddr == DETP_OFS_CTRL) || (paddr == DETP_OFS_STATUS) || (paddr == DETP_OFS_DBGCTL);
   wire [31:0] status_w = {20'h0, code_q, boot_mode_bit, 1'b0, halt_seen_q, dbgctl_q[DETP_DBGCTL_BREAK_BIT],
      trace_en_q};
   wire [31:0] rd_mux = (paddr == DETP_OFS_CTRL) ? {30'h0, pc_full_rate_q, trace_en_q} :
      (paddr == DETP_OFS_STATUS) ? status_w : (paddr == DETP_OFS_DBGCTL) ? dbgctl_q : 32'h0000_0000;
   assign apb_wr = psel && penable && pready && pwrite && !pslverr;
   assign apb_wdata = pwdata;
   assign apb_addr = paddr;

   // Read data is taken at setup so every answer comes from a flop with no wait state.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= setup;
         pslverr <= setup && !known;
         if (setup)
            prdata <= rd_mux;
      end
   end
endmodule

/* verification/detp_sva.sv */
// Checker with the concurrent properties of the debug emulator and trace port pins.
`timescale 1ns/1ps
module detp_sva
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic tdi,
   input wire logic trst_n,
   input wire logic trace_capture_clock,
   input wire logic [4:0] trace_status_bus_i,
   input wire logic [4:0] trace_status_bus_o,
   input wire logic [4:0] trace_status_bus_oe,
   input wire logic cold_reset_n,
   input wire logic debug_boot_in,
   input wire logic [4:0] boot_mode_bit,
   input wire logic debug_exception_req,
   input wire logic reset_exception_req,
   input wire logic debug_break_flag,
   input wire logic emulator_halt
);
   // ----------------------------------------
   // Clocking and reset-end sequences
   // ----------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // Exactly one of the two requests, chosen by the debug-boot level one cycle earlier.
   sequence boot_choice_s;
      (debug_exception_req == $past(debug_boot_in)) && (reset_exception_req == !$past(debug_boot_in));
   endsequence
   sequence boot_quiet_s;
      !debug_exception_req && !reset_exception_req;
   endsequence
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   cap_clock_third_a: assert property (trace_capture_clock |=> !trace_capture_clock ##1 !trace_capture_clock)
      else $error("capture clock high twice within three cycles");
   upper_pins_reserved_a: assert property (trace_status_bus_oe[4:3] == 2'h0 && trace_status_bus_o[4:3] == 2'h0)
      else $error("reserved status pins driven");
   boot_pins_input_a: assert property (!cold_reset_n |=> trace_status_bus_oe[2:0] == 3'h0)
      else $error("status pins driven during cold reset");
   trace_pins_output_a: assert property (cold_reset_n |=> trace_status_bus_oe[2:0] == 3'h7)
      else $error("status pins not driven after cold reset");
   boot_capture_a: assert property ($rose(cold_reset_n) |=> boot_mode_bit == $past(trace_status_bus_i))
      else $error("boot mode bits not taken at cold reset release");
   reset_end_exc_a: assert property ($rose(cold_reset_n) |=> boot_choice_s ##1 boot_quiet_s)
      else $error("wrong exception request at end of cold reset");
   break_flag_set_a: assert property (debug_boot_in && trst_n |-> ##[1:3] debug_break_flag)
      else $error("break flag not set by debug boot");
   halt_cause_a: assert property ($rose(emulator_halt) |-> !$past(tdi, 2) || !$past(tdi, 3) || !$past(tdi, 4))
      else $error("halt without interrupt on serial input");
   sync_delay_a: assert property ($fell(tdi) && !emulator_halt |-> !emulator_halt ##1 !emulator_halt)
      else $error("halt reached core before synchronisation");
endmodule

bind detp_top detp_sva chk_u (.pclk(pclk), .presetn(presetn), .tdi(tdi), .trst_n(trst_n),
   .trace_capture_clock(trace_capture_clock), .trace_status_bus_i(trace_status_bus_i),
   .trace_status_bus_o(trace_status_bus_o), .trace_status_bus_oe(trace_status_bus_oe),
   .cold_reset_n(cold_reset_n), .debug_boot_in(debug_boot_in), .boot_mode_bit(boot_mode_bit),
   .debug_exception_req(debug_exception_req), .reset_exception_req(reset_exception_req),
   .debug_break_flag(debug_break_flag), .emulator_halt(emulator_halt));

/* verification/detp_probe.sv */
// Emulator probe model that drives the test port and samples the trace pins.
`timescale 1ns/1ps
module detp_probe
(
   input wire logic pclk,
   input wire logic tdo_o,
   input wire logic tdo_oe,
   input wire logic trace_capture_clock,
   input wire logic [2:0] trace_code,
   output logic tck,
   output logic tms,
   output logic tdi,
   output logic [2:0] seen_code
);
   // Test clock stands low between frames; the serial input idles high so it never reads as an interrupt.
   initial
   begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b1;
      seen_code = 3'h0;
   end
   // Codes are taken only on capture clock cycles, when the device holds them stable.
   always @(posedge pclk)
   begin
      if (trace_capture_clock)
      begin
         seen_code <= trace_code;
      end
   end
   // One test clock period, seven core cycles low and six high, slow enough for the sampled tck.
   task automatic step(input logic m, input logic d, output logic q, output logic qe);
      @(posedge pclk);
      tms <= m;
      tdi <= d;
      repeat (6) @(posedge pclk);
      q = tdo_o;
      qe = tdo_oe;
      tck <= 1'b1;
      repeat (6) @(posedge pclk);
      tck <= 1'b0;
   endtask
   // Emulator interrupt: serial input held low long enough to cross the synchroniser.
   task automatic interrupt();
      @(posedge pclk);
      tdi <= 1'b0;
      repeat (8) @(posedge pclk);
      tdi <= 1'b1;
   endtask
endmodule

/* verification/tb_debug_emulator_trace_port.sv */
// Self-checking testbench of the debug emulator and trace port.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin err_count++; $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module tb_debug_emulator_trace_port
   import detp_pkg::*;
   ;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic trst_n = 1'b1;
   logic cold_reset_n = 1'b0;
   logic debug_boot_in = 1'b0;
   logic [2:0] core_code = 3'h3;
   logic core_debug_mode = 1'b0;
   logic [31:0] core_pc = 32'h0;
   logic [4:0] strap = 5'h0;
   wire [31:0] prdata;
   wire pready, pslverr, tck, tms, tdi, tdo_o, tdo_oe, cap_clk;
   wire [4:0] tsb_o, tsb_oe, boot_mode_bit;
   wire [2:0] seen_code;
   int err_count = 0;
   int total_checks = 0;
   logic [31:0] rd, id, sh;
   logic err, q, qe;
   logic [2:0] c;
   // Straps drive the status pins only while the device leaves them undriven.
   wire [4:0] tsb_i = (tsb_oe & tsb_o) | (~tsb_oe & strap);
   always #5 pclk = ~pclk;
   detp_top dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .tck(tck),
      .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo_o(tdo_o), .tdo_oe(tdo_oe), .trace_capture_clock(cap_clk),
      .trace_status_bus_i(tsb_i), .trace_status_bus_o(tsb_o), .trace_status_bus_oe(tsb_oe),
      .cold_reset_n(cold_reset_n), .debug_boot_in(debug_boot_in), .core_code(core_code),
      .core_debug_mode(core_debug_mode), .core_pc(core_pc), .boot_mode_bit(boot_mode_bit),
      .debug_exception_req(), .reset_exception_req(), .debug_break_flag(), .emulator_halt());
   detp_probe probe_u (.pclk(pclk), .tdo_o(tdo_o), .tdo_oe(tdo_oe), .trace_capture_clock(cap_clk),
      .trace_code(tsb_o[2:0]), .tck(tck), .tms(tms), .tdi(tdi), .seen_code(seen_code));
   // Debug mode overrides whatever the pipeline reports.
   function automatic logic [2:0] exp_code(input logic [2:0] c, input logic dbg);
      return dbg ? DETP_CODE_DEBUG_RUN : c;
   endfunction
   // One APB transfer; waits for pready however long it takes, so only the watchdog ends a hung wait.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic results();
      if (err_count == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // Watchdog sized well above the roughly 1400 cycles the sequence needs.
   initial
   begin
      repeat (30000) @(posedge pclk);
      err_count++;
      results();
   end
   initial
   begin
      void'($urandom(82));
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      // Two cold resets, the second one booting into debug.
      for (int k = 0; k < 2; k++)
      begin
         @(posedge pclk);
         strap <= 5'($urandom);
         debug_boot_in <= k[0];
         cold_reset_n <= 1'b0;
         repeat (4) @(posedge pclk);
         cold_reset_n <= 1'b1;
         repeat (3) @(posedge pclk);
         `CHK("boot_mode_bit", strap, boot_mode_bit)
         apb(1'b0, DETP_OFS_STATUS, 32'h0);
         `CHK("status_boot", strap, rd[8:4])
      end
      apb(1'b0, DETP_OFS_DBGCTL, 32'h0);
      `CHK("break_bit", 1'b1, rd[DETP_DBGCTL_BREAK_BIT])
      // Test reset clears the debug unit but leaves the captured boot bits alone.
      debug_boot_in <= 1'b0;
      repeat (2) @(posedge pclk);
      trst_n <= 1'b0;
      repeat (3) @(posedge pclk);
      trst_n <= 1'b1;
      apb(1'b0, DETP_OFS_DBGCTL, 32'h0);
      `CHK("break_cleared", 1'b0, rd[DETP_DBGCTL_BREAK_BIT])
      `CHK("boot_kept", strap, boot_mode_bit)
      apb(1'b0, 12'h00c, 32'h0);
      `CHK("unmapped_err", 1'b1, err)
      `CHK("unmapped_data", 32'h0, rd)
      // Identity word after test reset, then debug control selected through the instruction path and rewritten.
      for (int r = 0; r < 2; r++)
      begin
         debug_boot_in <= r[0];
         for (int i = 0; i < (r ? 13 : 9); i++)
         begin
            probe_u.step(r ? 1'(13'h0583 >> i) : (i < 5 || i == 6), r && i == 7, q, qe);
            id[i] = q;
         end
         if (r) `CHK("ir_capture", 4'h1, id[7:4])
         for (int i = 0; i < 32; i++)
         begin
            sh[i] = 1'($urandom);
            probe_u.step(i == 31, sh[i], q, qe);
            id[i] = q;
            if (i == 5) `CHK("tdo_oe_shift", 1'b1, qe)
         end
         if (r) `CHK("dbgctl_scan", DETP_DBGCTL_RESET | (32'h1 << DETP_DBGCTL_BREAK_BIT), id)
         else `CHK("idcode", DETP_IDCODE_VALUE, id)
         // The serial input is left high so that trace mode does not read it as an interrupt.
         probe_u.step(1'b1, 1'b1, q, qe);
         probe_u.step(1'b0, 1'b1, q, qe);
         probe_u.step(1'b0, 1'b1, q, qe);
         `CHK("tdo_oe_idle", 1'b0, qe)
      end
      apb(1'b0, DETP_OFS_DBGCTL, 32'h0);
      `CHK("dbgctl_update", sh | (32'h1 << DETP_DBGCTL_BREAK_BIT), rd)
      // Every trace code, then debug mode overriding a random one.
      apb(1'b1, DETP_OFS_CTRL, {30'h0, 1'($urandom), 1'b1});
      for (int i = 0; i < 9; i++)
      begin
         c = (i < 8) ? 3'(i) : 3'($urandom) | 3'h1;
         core_code <= c;
         core_debug_mode <= (i == 8);
         core_pc <= $urandom;
         repeat (10) @(posedge pclk);
         `CHK("trace_code", exp_code(c, i == 8), seen_code)
         // At either rate, slow or full, the capture clock cycle shows bit 0 of the loaded target.
         if (i == 4 || i == 6)
         begin
            do @(posedge pclk); while (!cap_clk);
            `CHK("trace_pc_bit", core_pc[0], tdo_o)
         end
      end
      // Emulator interrupt ends trace mode and stops the capture clock.
      probe_u.interrupt();
      repeat (6) @(posedge pclk);
      apb(1'b0, DETP_OFS_STATUS, 32'h0);
      `CHK("trace_off", 1'b0, rd[DETP_ST_TRACE_ACTIVE])
      `CHK("halt_seen", 1'b1, rd[DETP_ST_HALT_SEEN])
      `CHK("cap_clk_stopped", 1'b0, cap_clk)
      // Writing one to the halt flag clears it.
      apb(1'b1, DETP_OFS_STATUS, 32'h1 << DETP_ST_HALT_SEEN);
      apb(1'b0, DETP_OFS_STATUS, 32'h0);
      `CHK("halt_cleared", 1'b0, rd[DETP_ST_HALT_SEEN])
      results();
   end
endmodule
